// file: design/bdc_bridge_decode_error_control.sv
`timescale 1ns/1ps
// Contract
// - Video enabled: claim primary memory requests in A0000h..BFFFFh and forward downstream.
// - Video enabled: forward primary I/O with bits 31:16 zero, low bits in video ports.
// - Default video I/O decode ignores address bits 15:10, matching all aliases.
// - Video forwarding ignores alias enable and all configured I/O and memory windows.
// - Video I/O gated by I/O space enable; video memory by memory space enable.
// - Video disabled (reset): video addresses go downstream only through configured windows.
// - Alias setting applies only inside the I/O window and the lowest 64 KB.
// - Alias on: block downstream I/O to the top 768 bytes of each 1 KB.
// - Alias on: pass upstream secondary I/O to the top 768 bytes of each 1 KB.
// - Alias off (reset): forward every I/O address in the window downstream.
// - Forward system error only with forward enable, primary enable and secondary SERR.
// - System error forward enable resets to zero.
// - Parity response on: detect and report secondary address, attribute, data errors.
// - Parity response off (reset): ignore those secondary errors.
// - Always poison upstream data after an uncorrectable conventional bus data error.
// - Full port decode includes bits 15:10, only when video forwarding is enabled.
module bdc_bridge_decode_error_control (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst_n,
  // AXI4-Lite slave.
  input wire logic [bdc_pkg::BDC_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [bdc_pkg::BDC_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Primary-side request for downstream decode.
  input wire logic pri_req_valid,
  input wire bdc_pkg::bdc_req_s pri_req,
  output logic dn_claim,
  output logic dn_blocked,
  output bdc_pkg::bdc_dec_s dn_decision,
  // Secondary-side request for upstream decode.
  input wire logic sec_req_valid,
  input wire bdc_pkg::bdc_req_s sec_req,
  output logic up_claim,
  // Secondary bus clock and system error pin.
  input wire logic sec_bus_clk,
  input wire logic sec_serr_n,
  // Secondary error reports from the bus checker.
  input wire logic sec_addr_err,
  input wire logic sec_attr_err,
  input wire logic sec_data_err,
  input wire logic up_data_valid,
  // Results.
  output logic syserr_forward,
  output logic err_report,
  output logic up_data_poison,
  output logic irq
);
  import bdc_pkg::*;

  logic [BDC_BC_W-1:0] bridge_control_ff;
  logic [BDC_CMD_W-1:0] pri_cmd_ff;
  logic [31:0] io_base_ff, io_limit_ff, mem_base_ff, mem_limit_ff;
  logic [31:0] pmem_base_ff, pmem_limit_ff;
  logic [BDC_IRQ_W-1:0] irq_status_ff, irq_mask_ff;

  // Write helper: merge byte lanes.
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_val,
                                              input logic [31:0] new_val,
                                              input logic [3:0] strb);
    logic [31:0] res;
    res = old_val;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_val[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Control bits.
  wire parity_resp_en = bridge_control_ff[BDC_BC_PARITY_RESP];
  wire syserr_fwd_en = bridge_control_ff[BDC_BC_SYSERR_FWD];
  wire alias_block_en = bridge_control_ff[BDC_BC_ALIAS_BLOCK];
  wire video_en = bridge_control_ff[BDC_BC_VIDEO_EN];
  wire video_full_port_decode = bridge_control_ff[BDC_BC_VIDEO_FULL];
  wire io_space_enable = pri_cmd_ff[BDC_CMD_IO_EN];
  wire mem_space_enable = pri_cmd_ff[BDC_CMD_MEM_EN];
  wire primary_syserr_enable = pri_cmd_ff[BDC_CMD_SYSERR_EN];

  // Primary-side decode.
  wire [31:0] pa = pri_req.addr;
  wire p_low64k = (pa[31:16] == BDC_IO_HIGH_ZERO);
  wire p_vport = ((pa[9:0] >= BDC_VID_IO_A_LO) && (pa[9:0] <= BDC_VID_IO_A_HI)) ||
                 ((pa[9:0] >= BDC_VID_IO_B_LO) && (pa[9:0] <= BDC_VID_IO_B_HI));
  // Aliases only count when full decode is off; full decode has no effect unless
  // video forwarding is on, since the hit is gated by video_en below.
  wire p_alias_ok = !video_full_port_decode || (pa[15:10] == BDC_IO_ALIAS_ZERO);
  wire p_vid_io = p_low64k && p_vport && p_alias_ok;
  wire p_vid_mem = (pa >= BDC_VID_MEM_LO) && (pa <= BDC_VID_MEM_HI);
  wire p_in_io = (pa >= io_base_ff) && (pa <= io_limit_ff);
  wire p_in_mem = ((pa >= mem_base_ff) && (pa <= mem_limit_ff)) ||
                  ((pa >= pmem_base_ff) && (pa <= pmem_limit_ff));
  // The top 768 bytes of a 1 KB block are those with bits 9:8 non-zero.
  wire p_alias_top = (pa[9:8] != BDC_ALIAS_LOW_QTR);
  wire p_alias_blk = alias_block_en && pri_req.is_io && p_in_io && p_low64k &&
                     p_alias_top;
  wire p_video_hit = video_en && (pri_req.is_io ? p_vid_io : p_vid_mem);
  wire p_window_hit = pri_req.is_io ? (p_in_io && !p_alias_blk) : p_in_mem;
  wire p_space_en = pri_req.is_io ? io_space_enable : mem_space_enable;
  // Video hit wins over an alias block: one decision covers all decoders.
  wire p_claim = p_space_en && (p_video_hit || p_window_hit);
  wire p_blocked = p_space_en && p_alias_blk && !p_video_hit;

  // Secondary-side decode: pass up what the downstream windows do not own.
  wire [31:0] sa = sec_req.addr;
  wire s_low64k = (sa[31:16] == BDC_IO_HIGH_ZERO);
  wire s_vport = ((sa[9:0] >= BDC_VID_IO_A_LO) && (sa[9:0] <= BDC_VID_IO_A_HI)) ||
                 ((sa[9:0] >= BDC_VID_IO_B_LO) && (sa[9:0] <= BDC_VID_IO_B_HI));
  wire s_alias_ok = !video_full_port_decode || (sa[15:10] == BDC_IO_ALIAS_ZERO);
  wire s_vid_io = s_low64k && s_vport && s_alias_ok;
  wire s_vid_mem = (sa >= BDC_VID_MEM_LO) && (sa <= BDC_VID_MEM_HI);
  wire s_in_io = (sa >= io_base_ff) && (sa <= io_limit_ff);
  wire s_in_mem = ((sa >= mem_base_ff) && (sa <= mem_limit_ff)) ||
                  ((sa >= pmem_base_ff) && (sa <= pmem_limit_ff));
  wire s_alias_up = alias_block_en && s_in_io && s_low64k && (sa[9:8] != BDC_ALIAS_LOW_QTR);
  wire s_video_blk = video_en && (sec_req.is_io ? s_vid_io : s_vid_mem);
  wire s_claim = !s_video_blk && (sec_req.is_io ? (s_alias_up || !s_in_io) : !s_in_mem);

  // Secondary pins cross in through two flip-flops each.
  logic [1:0] clk_sync_ff, serr_sync_ff;
  logic clk_prev_ff, serr_sampled_ff;
  wire sec_clk_rise = clk_sync_ff[1] && !clk_prev_ff;
  wire nxt_serr_sampled = sec_clk_rise ? !serr_sync_ff[1] : serr_sampled_ff;

  // Event conditions.
  wire ev_syserr = syserr_fwd_en && primary_syserr_enable && serr_sampled_ff;
  wire ev_addr = parity_resp_en && sec_addr_err;
  wire ev_attr = parity_resp_en && sec_attr_err;
  wire ev_data = parity_resp_en && sec_data_err;
  wire ev_poison = up_data_valid && sec_data_err;
  wire [BDC_IRQ_W-1:0] ev_vec = {ev_poison, ev_data, ev_attr, ev_addr, ev_syserr};

  // AXI write channel: address and data may arrive in either order.
  logic aw_held_ff, w_held_ff;
  logic [BDC_ADDR_W-1:0] aw_addr_ff;
  logic [31:0] w_data_ff;
  logic [3:0] w_strb_ff;
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire wr_go = aw_held_ff && w_held_ff && !s_axi_bvalid;
  wire wr_bc = wr_go && (aw_addr_ff == BDC_OFS_BRIDGE_CTRL);
  wire wr_cmd = wr_go && (aw_addr_ff == BDC_OFS_PRI_CMD);
  wire wr_iob = wr_go && (aw_addr_ff == BDC_OFS_IO_BASE);
  wire wr_iol = wr_go && (aw_addr_ff == BDC_OFS_IO_LIMIT);
  wire wr_mb = wr_go && (aw_addr_ff == BDC_OFS_MEM_BASE);
  wire wr_ml = wr_go && (aw_addr_ff == BDC_OFS_MEM_LIMIT);
  wire wr_pb = wr_go && (aw_addr_ff == BDC_OFS_PMEM_BASE);
  wire wr_pl = wr_go && (aw_addr_ff == BDC_OFS_PMEM_LIMIT);
  wire wr_st = wr_go && (aw_addr_ff == BDC_OFS_IRQ_STATUS);
  wire wr_mk = wr_go && (aw_addr_ff == BDC_OFS_IRQ_MASK);
  wire wr_ro = wr_go && (aw_addr_ff == BDC_OFS_DECISION);
  wire wr_hit = wr_bc || wr_cmd || wr_iob || wr_iol || wr_mb || wr_ml || wr_pb || wr_pl ||
                wr_st || wr_mk || wr_ro;
  wire [31:0] wr_merged_bc = merge_bytes({16'h0000, bridge_control_ff}, w_data_ff, w_strb_ff);
  wire [31:0] wr_merged_cmd = merge_bytes({16'h0000, pri_cmd_ff}, w_data_ff, w_strb_ff);
  wire [31:0] wr_clr = merge_bytes(32'h0000_0000, w_data_ff, w_strb_ff);
  wire [31:0] wr_merged_mk = merge_bytes({27'h0000000, irq_mask_ff}, w_data_ff, w_strb_ff);

  // Sticky status: an event in the clearing cycle survives the clear.
  wire [BDC_IRQ_W-1:0] clr_vec = wr_st ? wr_clr[BDC_IRQ_W-1:0] : '0;
  wire [BDC_IRQ_W-1:0] nxt_irq_status = (irq_status_ff & ~clr_vec) | ev_vec;

  // AXI read decode.
  logic [BDC_ADDR_W-1:0] ar_addr;
  assign ar_addr = s_axi_araddr;
  wire ar_take = s_axi_arvalid && s_axi_arready;
  logic [31:0] rd_mux;
  logic rd_hit;
  always_comb begin
    rd_hit = 1'b1;
    case (ar_addr)
      BDC_OFS_BRIDGE_CTRL: rd_mux = {16'h0000, bridge_control_ff};
      BDC_OFS_PRI_CMD: rd_mux = {16'h0000, pri_cmd_ff};
      BDC_OFS_IO_BASE: rd_mux = io_base_ff;
      BDC_OFS_IO_LIMIT: rd_mux = io_limit_ff;
      BDC_OFS_MEM_BASE: rd_mux = mem_base_ff;
      BDC_OFS_MEM_LIMIT: rd_mux = mem_limit_ff;
      BDC_OFS_PMEM_BASE: rd_mux = pmem_base_ff;
      BDC_OFS_PMEM_LIMIT: rd_mux = pmem_limit_ff;
      BDC_OFS_IRQ_STATUS: rd_mux = {27'h0000000, irq_status_ff};
      BDC_OFS_IRQ_MASK: rd_mux = {27'h0000000, irq_mask_ff};
      BDC_OFS_DECISION: rd_mux = {28'h0000000, dn_decision};
      default: begin
        rd_mux = 32'h0000_0000;
        rd_hit = 1'b0;
      end
    endcase
  end

  // Synchronisers and secondary clock edge finder.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      clk_sync_ff <= 2'h0;
      serr_sync_ff <= 2'h3;
      clk_prev_ff <= 1'b0;
      serr_sampled_ff <= 1'b0;
    end else begin
      clk_sync_ff <= {clk_sync_ff[0], sec_bus_clk};
      serr_sync_ff <= {serr_sync_ff[0], sec_serr_n};
      clk_prev_ff <= clk_sync_ff[1];
      serr_sampled_ff <= nxt_serr_sampled;
    end
  end

  // Configuration registers.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      bridge_control_ff <= BDC_BC_RESET;
      pri_cmd_ff <= 16'h0000;
      io_base_ff <= 32'h0000_0000;
      io_limit_ff <= 32'h0000_0000;
      mem_base_ff <= 32'h0000_0000;
      mem_limit_ff <= 32'h0000_0000;
      pmem_base_ff <= 32'h0000_0000;
      pmem_limit_ff <= 32'h0000_0000;
      irq_mask_ff <= '0;
    end else begin
      if (wr_bc) bridge_control_ff <= wr_merged_bc[BDC_BC_W-1:0];
      if (wr_cmd) pri_cmd_ff <= wr_merged_cmd[BDC_CMD_W-1:0];
      if (wr_iob) io_base_ff <= merge_bytes(io_base_ff, w_data_ff, w_strb_ff);
      if (wr_iol) io_limit_ff <= merge_bytes(io_limit_ff, w_data_ff, w_strb_ff);
      if (wr_mb) mem_base_ff <= merge_bytes(mem_base_ff, w_data_ff, w_strb_ff);
      if (wr_ml) mem_limit_ff <= merge_bytes(mem_limit_ff, w_data_ff, w_strb_ff);
      if (wr_pb) pmem_base_ff <= merge_bytes(pmem_base_ff, w_data_ff, w_strb_ff);
      if (wr_pl) pmem_limit_ff <= merge_bytes(pmem_limit_ff, w_data_ff, w_strb_ff);
      if (wr_mk) irq_mask_ff <= wr_merged_mk[BDC_IRQ_W-1:0];
    end
  end

  // AXI write handshake.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      aw_addr_ff <= '0;
      w_data_ff <= 32'h0000_0000;
      w_strb_ff <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= BDC_RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_held_ff && !aw_take && !s_axi_bvalid;
      s_axi_wready <= !w_held_ff && !w_take && !s_axi_bvalid;
      if (aw_take) begin
        aw_held_ff <= 1'b1;
        aw_addr_ff <= s_axi_awaddr;
      end
      if (w_take) begin
        w_held_ff <= 1'b1;
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held_ff <= 1'b0;
        w_held_ff <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? BDC_RESP_OKAY : BDC_RESP_SLVERR;
        s_axi_awready <= 1'b0;
        s_axi_wready <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // AXI read handshake.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= BDC_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !ar_take;
      if (ar_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_hit ? BDC_RESP_OKAY : BDC_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Decode results, events and interrupt.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      dn_claim <= 1'b0;
      dn_blocked <= 1'b0;
      dn_decision <= '0;
      up_claim <= 1'b0;
      syserr_forward <= 1'b0;
      err_report <= 1'b0;
      up_data_poison <= 1'b0;
      irq_status_ff <= '0;
      irq <= 1'b0;
    end else begin
      dn_claim <= pri_req_valid && p_claim;
      dn_blocked <= pri_req_valid && p_blocked;
      if (pri_req_valid) begin
        dn_decision <= '{claim: p_claim, video_hit: p_video_hit,
                         alias_block: p_alias_blk, window_hit: p_window_hit};
      end
      up_claim <= sec_req_valid && s_claim;
      syserr_forward <= ev_syserr;
      err_report <= ev_addr || ev_attr || ev_data;
      up_data_poison <= ev_poison;
      irq_status_ff <= nxt_irq_status;
      irq <= |(nxt_irq_status & irq_mask_ff);
    end
  end
endmodule

// file: design/bdc_pkg.sv
package bdc_pkg;
  // Register byte addresses on the AXI4-Lite slave.
  localparam logic [7:0] BDC_OFS_BRIDGE_CTRL = 8'h00;
  localparam logic [7:0] BDC_OFS_PRI_CMD = 8'h04;
  localparam logic [7:0] BDC_OFS_IO_BASE = 8'h08;
  localparam logic [7:0] BDC_OFS_IO_LIMIT = 8'h0c;
  localparam logic [7:0] BDC_OFS_MEM_BASE = 8'h10;
  localparam logic [7:0] BDC_OFS_MEM_LIMIT = 8'h14;
  localparam logic [7:0] BDC_OFS_PMEM_BASE = 8'h18;
  localparam logic [7:0] BDC_OFS_PMEM_LIMIT = 8'h1c;
  localparam logic [7:0] BDC_OFS_IRQ_STATUS = 8'h20;
  localparam logic [7:0] BDC_OFS_IRQ_MASK = 8'h24;
  localparam logic [7:0] BDC_OFS_DECISION = 8'h28;
  localparam int BDC_ADDR_W = 8;

  // Bridge control field positions.
  localparam int BDC_BC_PARITY_RESP = 0;
  localparam int BDC_BC_SYSERR_FWD = 1;
  localparam int BDC_BC_ALIAS_BLOCK = 2;
  localparam int BDC_BC_VIDEO_EN = 3;
  localparam int BDC_BC_VIDEO_FULL = 4;
  localparam int BDC_BC_W = 16;
  localparam logic [15:0] BDC_BC_RESET = 16'h0000;

  // Primary command field positions.
  localparam int BDC_CMD_IO_EN = 0;
  localparam int BDC_CMD_MEM_EN = 1;
  localparam int BDC_CMD_SYSERR_EN = 8;
  localparam int BDC_CMD_W = 16;

  // Interrupt status bit positions.
  localparam int BDC_IRQ_SYSERR = 0;
  localparam int BDC_IRQ_ADDR_ERR = 1;
  localparam int BDC_IRQ_ATTR_ERR = 2;
  localparam int BDC_IRQ_DATA_ERR = 3;
  localparam int BDC_IRQ_POISON = 4;
  localparam int BDC_IRQ_W = 5;

  // Legacy video and alias decode constants.
  localparam logic [31:0] BDC_VID_MEM_LO = 32'h000a_0000;
  localparam logic [31:0] BDC_VID_MEM_HI = 32'h000b_ffff;
  localparam logic [9:0] BDC_VID_IO_A_LO = 10'h3b0;
  localparam logic [9:0] BDC_VID_IO_A_HI = 10'h3bb;
  localparam logic [9:0] BDC_VID_IO_B_LO = 10'h3c0;
  localparam logic [9:0] BDC_VID_IO_B_HI = 10'h3df;
  localparam logic [15:0] BDC_IO_HIGH_ZERO = 16'h0000;
  localparam logic [5:0] BDC_IO_ALIAS_ZERO = 6'h00;
  localparam logic [1:0] BDC_ALIAS_LOW_QTR = 2'h0;

  localparam logic [1:0] BDC_RESP_OKAY = 2'h0;
  localparam logic [1:0] BDC_RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [31:0] addr;
    logic is_io;
  } bdc_req_s;

  typedef struct packed {
    logic claim;
    logic video_hit;
    logic alias_block;
    logic window_hit;
  } bdc_dec_s;
endpackage

// file: verif/bdc_chk_assertions.sv
`timescale 1ns/1ps
module bdc_chk (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst_n,
  // Decode results.
  input wire logic pri_req_valid,
  input wire bdc_pkg::bdc_req_s pri_req,
  input wire logic dn_claim,
  input wire logic dn_blocked,
  input wire bdc_pkg::bdc_dec_s dn_decision,
  input wire logic sec_req_valid,
  input wire logic up_claim,
  // Error path.
  input wire logic sec_addr_err,
  input wire logic sec_attr_err,
  input wire logic sec_data_err,
  input wire logic up_data_valid,
  input wire logic err_report,
  input wire logic up_data_poison,
  // Register bus answers.
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata
);
  import bdc_pkg::*;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  a_claim_cause: assert property (dn_claim |-> $past(pri_req_valid))
    else $error("claim pulse without a request");
  a_claim_flag: assert property (dn_claim |-> dn_decision.claim)
    else $error("claim pulse disagrees with decision");
  a_block_excl: assert property (dn_blocked |-> !dn_claim && dn_decision.alias_block
    && $past(pri_req.is_io)) else $error("blocked request also claimed");
  a_alias_io_only: assert property ($past(pri_req_valid && !pri_req.is_io)
    |-> !dn_decision.alias_block) else $error("alias block on a memory request");
  a_up_cause: assert property (up_claim |-> $past(sec_req_valid))
    else $error("upstream claim without a request");
  a_poison_set: assert property ($past(rst_n) && $past(up_data_valid && sec_data_err)
    |-> up_data_poison) else $error("bad data not poisoned");
  a_poison_only: assert property (up_data_poison |-> $past(up_data_valid && sec_data_err))
    else $error("poison without a data error");
  a_err_cause: assert property (err_report |-> $past(sec_addr_err || sec_attr_err
    || sec_data_err)) else $error("error report without an error");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write response dropped early");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata)) else $error("read data dropped early");
endmodule

// file: verif/bdc_sec_agent.sv
`timescale 1ns/1ps
module bdc_sec_agent (
  // Bench controls.
  input wire logic run,
  input wire logic serr_on,
  // Secondary bus pins.
  output logic sec_bus_clk,
  output logic sec_serr_n
);
  initial begin
    sec_bus_clk = 1'b0;
    sec_serr_n = 1'b1;
  end
  // The bus clock stands still low while no traffic is wanted.
  always #40 sec_bus_clk = run ? ~sec_bus_clk : 1'b0;
  // Driven on the falling edge so the rising edge samples a settled level.
  always @(negedge sec_bus_clk) sec_serr_n <= ~serr_on;
endmodule

// file: verif/testbench.sv
`timescale 1ns/1ps
module testbench;
  import bdc_pkg::*;
  logic core_clk = 1'b0, rst_n = 1'b0, run = 1'b0, serr_on = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, pri_req_valid = 1'b0, sec_req_valid = 1'b0;
  logic sec_addr_err = 1'b0, sec_attr_err = 1'b0, sec_data_err = 1'b0, up_data_valid = 1'b0;
  bdc_req_s pri_req = '0, sec_req = '0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic dn_claim, dn_blocked, up_claim, syserr_forward, err_report, up_data_poison, irq;
  bdc_dec_s dn_decision;
  wire logic sec_bus_clk, sec_serr_n;
  int err_total = 0, compares = 0;

  bdc_bridge_decode_error_control i_bdc_bridge_decode_error_control (.*);
  bdc_sec_agent i_bdc_sec_agent (.*);
  always #5 core_clk = ~core_clk;

  task end_sim;
    $display("mismatches %0d comparisons %0d", err_total, compares);
    if (err_total == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    compares++;
    if (s !== e) begin
      $display("MISMATCH %s expected %h seen %h", n, e, s);
      err_total++;
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = BDC_RESP_OKAY);
    int i;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
    if (i == 50) begin
      err_total++;
      end_sim();
    end
  endtask

  task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = BDC_RESP_OKAY);
    int i;
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    chk("rdata", e, s_axi_rdata);
    chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
    if (i == 50) begin
      err_total++;
      end_sim();
    end
  endtask

  task pri(input logic [31:0] a, input logic io, input logic [3:0] ed, input logic eb);
    @(posedge core_clk);
    pri_req_valid <= 1'b1;
    pri_req <= '{addr: a, is_io: io};
    @(posedge core_clk);
    pri_req_valid <= 1'b0;
    #1;
    chk("dn_decision", {28'h0, ed}, {28'h0, dn_decision});
    chk("dn_claim", {31'h0, ed[3]}, {31'h0, dn_claim});
    chk("dn_blocked", {31'h0, eb}, {31'h0, dn_blocked});
  endtask

  task sec(input logic [31:0] a, input logic e);
    @(posedge core_clk);
    sec_req_valid <= 1'b1;
    sec_req <= '{addr: a, is_io: 1'b1};
    @(posedge core_clk);
    sec_req_valid <= 1'b0;
    #1;
    chk("up_claim", {31'h0, e}, {31'h0, up_claim});
  endtask

  // Order of v: address, attribute, data error, upstream beat.
  task ev(input logic [3:0] v, input logic er, input logic ep);
    @(posedge core_clk);
    {sec_addr_err, sec_attr_err, sec_data_err, up_data_valid} <= v;
    @(posedge core_clk);
    {sec_addr_err, sec_attr_err, sec_data_err, up_data_valid} <= 4'h0;
    #1;
    chk("err_report", {31'h0, er}, {31'h0, err_report});
    chk("up_data_poison", {31'h0, ep}, {31'h0, up_data_poison});
  endtask

  // Covers the synchroniser latency plus a whole secondary clock period.
  task fwd(input logic e);
    repeat (40) @(posedge core_clk);
    #1;
    chk("syserr_forward", {31'h0, e}, {31'h0, syserr_forward});
  endtask

  task lvl(input logic e);
    repeat (2) @(posedge core_clk);
    #1;
    chk("irq", {31'h0, e}, {31'h0, irq});
  endtask

  initial begin
    #500000;
    err_total++;
    end_sim();
  end

  initial begin
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(BDC_OFS_BRIDGE_CTRL, 32'h0);
    rd(8'h40, 32'h0, BDC_RESP_SLVERR);
    wr(8'h40, 32'h1, BDC_RESP_SLVERR);
    wr(BDC_OFS_PRI_CMD, 32'h103);
    wr(BDC_OFS_IO_BASE, 32'h1000);
    wr(BDC_OFS_IO_LIMIT, 32'h1fff);
    pri(32'h000a_0000, 1'b0, 4'b0000, 1'b0);
    pri(32'h0000_03c0, 1'b1, 4'b0000, 1'b0);
    pri(32'h0000_1100, 1'b1, 4'b1001, 1'b0);
    sec(32'h0000_1100, 1'b0);
    wr(BDC_OFS_BRIDGE_CTRL, 32'h0c);
    pri(32'h0000_1100, 1'b1, 4'b0010, 1'b1);
    pri(32'h0000_1000, 1'b1, 4'b1001, 1'b0);
    pri(32'h0000_1100, 1'b0, 4'b0000, 1'b0);
    pri(32'h0000_2100, 1'b1, 4'b0000, 1'b0);
    pri(32'h0000_7fc0, 1'b1, 4'b1100, 1'b0);
    pri(32'h0000_13c0, 1'b1, 4'b1110, 1'b0);
    pri(32'h0000_03bb, 1'b1, 4'b1100, 1'b0);
    pri(32'h0000_03bc, 1'b1, 4'b0000, 1'b0);
    pri(32'h0001_03c0, 1'b1, 4'b0000, 1'b0);
    pri(32'h000b_ffff, 1'b0, 4'b1100, 1'b0);
    pri(32'h000c_0000, 1'b0, 4'b0000, 1'b0);
    sec(32'h0000_1100, 1'b1);
    sec(32'h0000_1000, 1'b0);
    wr(BDC_OFS_BRIDGE_CTRL, 32'h1c);
    pri(32'h0000_7fc0, 1'b1, 4'b0000, 1'b0);
    pri(32'h0000_03c0, 1'b1, 4'b1100, 1'b0);
    wr(BDC_OFS_BRIDGE_CTRL, 32'h10);
    pri(32'h0000_03c0, 1'b1, 4'b0000, 1'b0);
    wr(BDC_OFS_BRIDGE_CTRL, 32'h08);
    wr(BDC_OFS_PRI_CMD, 32'h001);
    pri(32'h000a_0000, 1'b0, 4'b0100, 1'b0);
    pri(32'h0000_03c0, 1'b1, 4'b1100, 1'b0);
    wr(BDC_OFS_PRI_CMD, 32'h002);
    pri(32'h0000_03c0, 1'b1, 4'b0100, 1'b0);
    wr(BDC_OFS_PRI_CMD, 32'h103);
    run <= 1'b1;
    serr_on <= 1'b1;
    wr(BDC_OFS_BRIDGE_CTRL, 32'h02);
    fwd(1'b1);
    wr(BDC_OFS_PRI_CMD, 32'h003);
    fwd(1'b0);
    wr(BDC_OFS_PRI_CMD, 32'h103);
    wr(BDC_OFS_BRIDGE_CTRL, 32'h00);
    fwd(1'b0);
    serr_on <= 1'b0;
    wr(BDC_OFS_BRIDGE_CTRL, 32'h02);
    fwd(1'b0);
    run <= 1'b0;
    wr(BDC_OFS_BRIDGE_CTRL, 32'h00);
    ev(4'b0011, 1'b0, 1'b1);
    ev(4'b1000, 1'b0, 1'b0);
    wr(BDC_OFS_BRIDGE_CTRL, 32'h01);
    ev(4'b1000, 1'b1, 1'b0);
    ev(4'b0100, 1'b1, 1'b0);
    ev(4'b0011, 1'b1, 1'b1);
    rd(BDC_OFS_IRQ_STATUS, 32'h1f);
    lvl(1'b0);
    wr(BDC_OFS_IRQ_MASK, 32'h02);
    lvl(1'b1);
    wr(BDC_OFS_IRQ_STATUS, 32'h02);
    lvl(1'b0);
    rd(BDC_OFS_IRQ_STATUS, 32'h1d);
    end_sim();
  end
endmodule

bind bdc_bridge_decode_error_control bdc_chk i_bdc_chk (.*);
